/* File: hw/vrv_regs.sv */
`timescale 1ns/100ps
// Operation
// RULE1: Both instruction code bits clear themselves once the instruction executes.
// RULE2: Host issues no play or record while busy and active both read one.
// RULE3: Voice flag and silence level show only while voice detection is on.
// RULE4: Detect bit 7 reads one for voice, zero for silence.
// RULE5: Detect bits 6:5 give the transmit silence level band.
// RULE6: Detect bit 1 reads one while a serial address transfer runs.
// RULE7: Detect bit 0 reads one while recording or playback runs.
// RULE8: Detect register is read-only; writes leave it unchanged.
// RULE9: Start X is 13 bits, reversed across low and high registers.
// RULE10: Y-address register holds bit-reversed address until rewritten.
// RULE11: Stop X low register holds bits 0 to 7, bit 0 at bit 7.
// RULE12: Stop X bits 8 to 12 sit in high register bits 7 to 3.
// RULE13: All registers reset to zero; unused bits read zero.
// RULE14: Select bits are stored as written and passed on unchanged.
`include "vrv_map.svh"
module vrv_regs
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire vrv_pkg::vrv_serial_stat_t serialStat,
    input wire logic voiceRaw,
    input wire logic [1:0] silenceLevelRaw,
    output vrv_pkg::vrv_mem_ctrl_t memCtrl,
    output vrv_pkg::vrv_vox_cfg_t voxCfg,
    output logic [12:0] startX,
    output logic [12:0] stopX,
    output logic [7:0] yAddress,
    output logic irq
);
    import vrv_pkg::*;

    vrv_regs_state_t st_r;
    vrv_regs_state_t st_nxt;
    vrv_bus_req_t req;
    logic [7:0] rdByte;
    logic [2:0] voxSync;
    logic [7:0] detectNow;
    logic [3:0] events;
    logic [3:0] irqClear;
    logic cmdWrite;
    logic [7:0] rdStartHi;
    logic [7:0] rdStopHi;

    // Address bit 0 sits in the register's most significant bit
    function automatic logic [7:0] bitRev(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++)
        begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction : bitRev

    // Joins a low and a high register into one 13-bit address
    function automatic logic [12:0] joinX(
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        logic [7:0] h;
        h = bitRev(hi);
        return {h[4:0], bitRev(lo)};
    endfunction : joinX

    function automatic logic hits(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        return addr == ofs;
    endfunction : hits

    vrv_ahb_if u_bus
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .rdByte(rdByte),
        .req(req)
    );

    // Detector levels come from the analog side and are synchronised
    vrv_sync u_voxSync
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .rawIn({voiceRaw, silenceLevelRaw}),
        .syncOut(voxSync)
    );

    // Fresh detect value; voice fields forced to zero when detection off
    always_comb
    begin
        detectNow = '0;
        if (st_r.voxCtrl[`VRV_VOX_EN]) // RULE3
        begin
            detectNow[`VRV_DET_VOICE] = voxSync[2]; // RULE4
            detectNow[`VRV_DET_LVL_MSB:`VRV_DET_LVL_LSB] =
                voxSync[1:0]; // RULE5
        end
        detectNow[`VRV_DET_BUSY] = serialStat.ifBusy; // RULE6
        detectNow[`VRV_DET_ACTIVE] = serialStat.recordPlayActive; // RULE7
    end

    assign cmdWrite = req.wr && hits(req.addr, `VRV_OFS_MEM_CTRL);

    // Interrupt sources
    always_comb
    begin
        events = '0;
        events[`VRV_EV_DONE] = serialStat.instrDone;
        events[`VRV_EV_VOICE] = detectNow[`VRV_DET_VOICE]
            && !st_r.detect[`VRV_DET_VOICE];
        events[`VRV_EV_ENDED] = st_r.detect[`VRV_DET_ACTIVE]
            && !detectNow[`VRV_DET_ACTIVE];
        // Command written while the interface is both busy and active
        events[`VRV_EV_CONFLICT] = cmdWrite
            && (req.wdata[`VRV_CMD_MSB:`VRV_CMD_LSB] != 2'h0)
            && st_r.detect[`VRV_DET_BUSY]
            && st_r.detect[`VRV_DET_ACTIVE]; // RULE2
    end

    always_comb
    begin
        irqClear = '0;
        if (req.wr && hits(req.addr, `VRV_OFS_IRQ_CLR))
        begin
            irqClear = req.wdata[3:0];
        end
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.detect = detectNow; // RULE8
        // Execution clears the code; a host write in the same cycle wins
        if (serialStat.instrDone)
        begin
            st_nxt.memCtrl[`VRV_CMD_MSB:`VRV_CMD_LSB] = 2'h0; // RULE1
        end
        if (cmdWrite)
        begin
            st_nxt.memCtrl = req.wdata & `VRV_MASK_MEM_CTRL; // RULE14
        end
        if (req.wr)
        begin
            if (hits(req.addr, `VRV_OFS_VOX_CTRL))
            begin
                st_nxt.voxCtrl = req.wdata;
            end
            if (hits(req.addr, `VRV_OFS_START_LO))
            begin
                st_nxt.startLo = req.wdata; // RULE9
            end
            if (hits(req.addr, `VRV_OFS_START_HI))
            begin
                st_nxt.startHi = req.wdata & `VRV_MASK_HIGH_X; // RULE9
            end
            if (hits(req.addr, `VRV_OFS_Y_ADDR))
            begin
                st_nxt.yAddr = req.wdata; // RULE10
            end
            if (hits(req.addr, `VRV_OFS_STOP_LO))
            begin
                st_nxt.stopLo = req.wdata; // RULE11
            end
            if (hits(req.addr, `VRV_OFS_STOP_HI))
            begin
                st_nxt.stopHi = req.wdata & `VRV_MASK_HIGH_X; // RULE12
            end
            if (hits(req.addr, `VRV_OFS_IRQ_EN))
            begin
                st_nxt.irqEn = req.wdata[3:0];
            end
        end
        // New events win over a clear in the same cycle
        st_nxt.irqStat = (st_r.irqStat & ~irqClear) | events;
        st_nxt.irq = |(st_nxt.irqStat & st_nxt.irqEn);
    end

    assign rdStartHi = st_r.startHi;
    assign rdStopHi = st_r.stopHi;

    // Read multiplexer; unmapped addresses read zero
    always_comb
    begin
        rdByte = '0;
        unique case (1'b1)
            hits(req.addr, `VRV_OFS_MEM_CTRL):
                rdByte = st_r.memCtrl;
            hits(req.addr, `VRV_OFS_VOX_CTRL):
                rdByte = st_r.voxCtrl;
            hits(req.addr, `VRV_OFS_DETECT):
                rdByte = st_r.detect;
            hits(req.addr, `VRV_OFS_START_LO):
                rdByte = st_r.startLo;
            hits(req.addr, `VRV_OFS_START_HI):
                rdByte = rdStartHi;
            hits(req.addr, `VRV_OFS_Y_ADDR):
                rdByte = st_r.yAddr;
            hits(req.addr, `VRV_OFS_STOP_LO):
                rdByte = st_r.stopLo;
            hits(req.addr, `VRV_OFS_STOP_HI):
                rdByte = rdStopHi;
            hits(req.addr, `VRV_OFS_IRQ_STAT):
                rdByte = {4'h0, st_r.irqStat};
            hits(req.addr, `VRV_OFS_IRQ_EN):
                rdByte = {4'h0, st_r.irqEn};
            default:
                rdByte = '0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_r.memCtrl <= `VRV_RST_BYTE; // RULE13
            st_r.voxCtrl <= `VRV_RST_BYTE;
            st_r.detect <= `VRV_RST_BYTE;
            st_r.startLo <= `VRV_RST_BYTE;
            st_r.startHi <= `VRV_RST_BYTE;
            st_r.yAddr <= `VRV_RST_BYTE;
            st_r.stopLo <= `VRV_RST_BYTE;
            st_r.stopHi <= `VRV_RST_BYTE;
            st_r.irqStat <= `VRV_RST_IRQ;
            st_r.irqEn <= `VRV_RST_IRQ;
            st_r.irq <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs are wiring of registered state only
    assign memCtrl.sendOrRecordSelect = st_r.memCtrl[7]; // RULE14
    assign memCtrl.memoryTypeSelect = st_r.memCtrl[6];
    assign memCtrl.memoryClockSelect = st_r.memCtrl[5];
    assign memCtrl.instructionCode =
        st_r.memCtrl[`VRV_CMD_MSB:`VRV_CMD_LSB];
    assign voxCfg.enable = st_r.voxCtrl[`VRV_VOX_EN];
    assign voxCfg.settings = st_r.voxCtrl[6:0];
    assign startX = joinX(st_r.startLo, st_r.startHi); // RULE9
    assign stopX = joinX(st_r.stopLo, st_r.stopHi); // RULE12
    assign yAddress = bitRev(st_r.yAddr); // RULE10
    assign irq = st_r.irq;

endmodule : vrv_regs

/* File: hw/vrv_map.svh */
`ifndef VRV_MAP_SVH
`define VRV_MAP_SVH

// Byte offsets on the register bus
`define VRV_OFS_MEM_CTRL 8'h00
`define VRV_OFS_VOX_CTRL 8'h04
`define VRV_OFS_DETECT 8'h08
`define VRV_OFS_START_LO 8'h0c
`define VRV_OFS_START_HI 8'h10
`define VRV_OFS_Y_ADDR 8'h14
`define VRV_OFS_STOP_LO 8'h18
`define VRV_OFS_STOP_HI 8'h1c
`define VRV_OFS_IRQ_STAT 8'h20
`define VRV_OFS_IRQ_EN 8'h24
`define VRV_OFS_IRQ_CLR 8'h28

// Reset values and masks of implemented bits
`define VRV_RST_BYTE 8'h00
`define VRV_RST_IRQ 4'h0
`define VRV_MASK_MEM_CTRL 8'he3
`define VRV_MASK_HIGH_X 8'hf8
`define VRV_CMD_LSB 0
`define VRV_CMD_MSB 1

// Detect register fields and the voice control enable bit
`define VRV_DET_VOICE 7
`define VRV_DET_LVL_MSB 6
`define VRV_DET_LVL_LSB 5
`define VRV_DET_BUSY 1
`define VRV_DET_ACTIVE 0
`define VRV_VOX_EN 7

// Interrupt event bits
`define VRV_EV_DONE 0
`define VRV_EV_VOICE 1
`define VRV_EV_ENDED 2
`define VRV_EV_CONFLICT 3

`define VRV_HTRANS_NONSEQ 2'h2

`endif

/* File: hw/vrv_pkg.sv */
package vrv_pkg;

    typedef struct packed {
        logic sendOrRecordSelect;
        logic memoryTypeSelect;
        logic memoryClockSelect;
        logic [1:0] instructionCode;
    } vrv_mem_ctrl_t;

    typedef struct packed {
        logic enable;
        logic [6:0] settings;
    } vrv_vox_cfg_t;

    typedef struct packed {
        logic instrDone;
        logic ifBusy;
        logic recordPlayActive;
    } vrv_serial_stat_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vrv_bus_req_t;

    typedef struct packed {
        logic aValid;
        logic aWrite;
        logic [7:0] aAddr;
        logic readyOut;
        logic [31:0] rdata;
    } vrv_ahb_state_t;

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] level;
    } vrv_sync_state_t;

    typedef struct packed {
        logic [7:0] memCtrl;
        logic [7:0] voxCtrl;
        logic [7:0] detect;
        logic [7:0] startLo;
        logic [7:0] startHi;
        logic [7:0] yAddr;
        logic [7:0] stopLo;
        logic [7:0] stopHi;
        logic [3:0] irqStat;
        logic [3:0] irqEn;
        logic irq;
    } vrv_regs_state_t;

endpackage : vrv_pkg

/* File: hw/vrv_sync.sv */
`timescale 1ns/100ps
module vrv_sync
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] rawIn,
    output logic [2:0] syncOut
);
    import vrv_pkg::*;

    vrv_sync_state_t st_r;
    vrv_sync_state_t st_nxt;

    // Level follows only once the second and third stages agree
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = rawIn;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3)
        begin
            st_nxt.level = st_r.s3;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign syncOut = st_r.level;

endmodule : vrv_sync

/* File: hw/vrv_ahb_if.sv */
`timescale 1ns/100ps
`include "vrv_map.svh"
module vrv_ahb_if
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [7:0] rdByte,
    output vrv_pkg::vrv_bus_req_t req
);
    import vrv_pkg::*;

    vrv_ahb_state_t st_r;
    vrv_ahb_state_t st_nxt;

    // Reads take one wait state so that read data leave a flip-flop
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.aValid = 1'b0;
        if (st_r.aValid && !st_r.aWrite && !st_r.readyOut)
        begin
            st_nxt.rdata = {24'h000000, rdByte};
            st_nxt.readyOut = 1'b1;
        end
        if (hsel && hready && htrans == `VRV_HTRANS_NONSEQ)
        begin
            st_nxt.aValid = 1'b1;
            st_nxt.aWrite = hwrite;
            st_nxt.aAddr = {haddr[7:2], 2'h0};
            st_nxt.readyOut = hwrite;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.readyOut <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign req.wr = st_r.aValid && st_r.aWrite;
    assign req.rd = st_r.aValid && !st_r.aWrite && !st_r.readyOut;
    assign req.addr = st_r.aAddr;
    assign req.wdata = hwdata[7:0];
    assign hreadyout = st_r.readyOut;
    assign hrdata = st_r.rdata;
    assign hresp = 1'b0;

endmodule : vrv_ahb_if

/* File: test/vrv_regs_checker.sv */
`timescale 1ns/100ps
module vrv_regs_checker
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire vrv_pkg::vrv_serial_stat_t serialStat,
    input wire vrv_pkg::vrv_mem_ctrl_t memCtrl,
    input wire vrv_pkg::vrv_vox_cfg_t voxCfg,
    input wire logic [12:0] startX,
    input wire logic [12:0] stopX,
    input wire logic [7:0] yAddress,
    input wire logic irq
);
    import vrv_pkg::*;
    logic take;
    logic [1:0] st2;
    logic dW_r;
    logic wDone_r;
    logic [5:0] dIdx_r;
    logic [5:0] wIdx_r;
    logic [7:0] rv_r;
    assign take = hsel && hready && htrans == 2'h2;
    assign st2 = {serialStat.ifBusy, serialStat.recordPlayActive};
    // Writes have no wait state, so the data phase ends one edge later
    always_ff @(posedge sys_clk)
    begin
        dW_r <= !rst && take && hwrite;
        wDone_r <= !rst && dW_r;
        if (take)
            dIdx_r <= haddr[7:2];
        wIdx_r <= dIdx_r;
        if (dW_r)
            rv_r <= {<<{hwdata[7:0]}};
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_rdDet;
        take && !hwrite && haddr[7:2] == 6'h2;
    endsequence
    sequence s_rdWait;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_cmdClear;
        serialStat.instrDone && !(dW_r && dIdx_r == 6'h0)
            |=> memCtrl.instructionCode == 2'h0;
    endproperty
    a_cmdClear: assert property (p_cmdClear)
        else $error("command bits not cleared");
    property p_voxOff;
        s_rdDet ##0 (!voxCfg.enable && !$past(voxCfg.enable))
            |=> s_rdWait ##0 hrdata[7:5] == 3'h0;
    endproperty
    a_voxOff: assert property (p_voxOff)
        else $error("voice bits shown while off");
    // Read data show the busy and active levels seen at the address edge
    property p_detBusy;
        s_rdDet |=> s_rdWait ##0 hrdata[1:0] == $past(st2, 2);
    endproperty
    a_detBusy: assert property (p_detBusy)
        else $error("busy or active bit wrong");
    property p_startLo;
        wDone_r && wIdx_r == 6'h3 |-> ##[0:1] startX[7:0] == rv_r;
    endproperty
    a_startLo: assert property (p_startLo)
        else $error("start x low wrong");
    property p_startHi;
        wDone_r && wIdx_r == 6'h4 |-> ##[0:1] startX[12:8] == rv_r[4:0];
    endproperty
    a_startHi: assert property (p_startHi)
        else $error("start x high wrong");
    property p_yAddr;
        wDone_r && wIdx_r == 6'h5 |-> ##[0:1] yAddress == rv_r;
    endproperty
    a_yAddr: assert property (p_yAddr)
        else $error("y address wrong");
    property p_stopLo;
        wDone_r && wIdx_r == 6'h6 |-> ##[0:1] stopX[7:0] == rv_r;
    endproperty
    a_stopLo: assert property (p_stopLo)
        else $error("stop x low wrong");
    property p_stopHi;
        wDone_r && wIdx_r == 6'h7 |-> ##[0:1] stopX[12:8] == rv_r[4:0];
    endproperty
    a_stopHi: assert property (p_stopHi)
        else $error("stop x high wrong");
    property p_sel;
        wDone_r && wIdx_r == 6'h0
            |-> ##[0:1] memCtrl[4:2] == {rv_r[0], rv_r[1], rv_r[2]};
    endproperty
    a_sel: assert property (p_sel)
        else $error("select bits wrong");
    property p_rst;
        @(posedge sys_clk) disable iff (1'b0)
        rst |=> !irq && hreadyout && hrdata == 32'h0 && startX == 13'h0
            && stopX == 13'h0 && yAddress == 8'h0 && memCtrl == 5'h0;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not cleared by reset");
endmodule : vrv_regs_checker

bind vrv_regs vrv_regs_checker u_vrv_regs_checker
(
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .serialStat(serialStat),
    .memCtrl(memCtrl), .voxCfg(voxCfg), .startX(startX), .stopX(stopX),
    .yAddress(yAddress), .irq(irq)
);

/* File: test/vrv_far_model.sv */
`timescale 1ns/100ps
module vrv_far_model
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] lat,
    input wire vrv_pkg::vrv_mem_ctrl_t memCtrl,
    output vrv_pkg::vrv_serial_stat_t serialStat
);
    import vrv_pkg::*;
    logic [3:0] cnt;
    // Busy for lat cycles per instruction, then one done pulse
    always_ff @(posedge sys_clk)
    begin
        serialStat.instrDone <= 1'b0;
        if (rst)
        begin
            cnt <= 4'h0;
            serialStat <= 3'h0;
        end
        else if (cnt != 4'h0)
        begin
            cnt <= cnt - 4'h1;
            serialStat.ifBusy <= cnt != 4'h1;
            serialStat.instrDone <= cnt == 4'h1;
        end
        else if (memCtrl.instructionCode != 2'h0 && !serialStat.instrDone)
        begin
            cnt <= lat;
            serialStat.ifBusy <= 1'b1;
            serialStat.recordPlayActive <= memCtrl.instructionCode[1];
        end
    end
endmodule : vrv_far_model

/* File: test/vrv_regs_tb.sv */
`timescale 1ns/100ps
module vrv_regs_tb;
    import vrv_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic voiceRaw = 1'b0;
    logic [1:0] silenceLevelRaw = 2'h0;
    logic [3:0] lat = 4'h6;
    vrv_serial_stat_t serialStat;
    vrv_mem_ctrl_t memCtrl;
    vrv_vox_cfg_t voxCfg;
    logic [12:0] startX;
    logic [12:0] stopX;
    logic [7:0] yAddress;
    logic irq;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [31:0] rnd = 32'he482a20e;
    logic [7:0] refReg [8] = '{default: 8'h00};
    logic [7:0] msk [8] = '{8'he0, 8'hff, 8'h00, 8'hff, 8'hf8, 8'hff,
        8'hff, 8'hf8};
    always #50 sys_clk = ~sys_clk;
    vrv_regs u_vrv_regs (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .serialStat(serialStat),
        .voiceRaw(voiceRaw), .silenceLevelRaw(silenceLevelRaw),
        .memCtrl(memCtrl), .voxCfg(voxCfg), .startX(startX),
        .stopX(stopX), .yAddress(yAddress), .irq(irq));
    vrv_far_model u_vrv_far_model (.sys_clk(sys_clk), .rst(rst),
        .lat(lat), .memCtrl(memCtrl), .serialStat(serialStat));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] rev8(input logic [7:0] v);
        return {<<{v}};
    endfunction : rev8
    function automatic logic [31:0] xaddr(input logic [7:0] lo, hi);
        logic [15:0] t;
        t = {rev8(hi), rev8(lo)};
        return {19'h0, t[12:0]};
    endfunction : xaddr
    task results;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk
    task waitRdy;
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            chk(32'(hreadyout), 32'h1);
            results();
        end
    endtask : waitRdy
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] r);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        waitRdy();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        waitRdy();
        r = hrdata;
        hsel <= 1'b0;
    endtask : xfer
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 8'h00, r);
        chk(r, exp);
        chk(32'(hresp), 32'h0);
    endtask : rd
    task cmd(input logic [7:0] d);
        int i;
        for (i = 0; i < 40 && serialStat.ifBusy && serialStat.recordPlayActive;
            i++)
            @(posedge sys_clk);
        if (serialStat.ifBusy && serialStat.recordPlayActive)
        begin
            chk(32'(serialStat.ifBusy), 32'h0);
            results();
        end
        wr(8'h00, d);
        @(negedge sys_clk);
        chk(32'(memCtrl[4:2]), 32'(d[7:5]));
        for (i = 0; i < 40 && memCtrl.instructionCode !== 2'h0; i++)
            @(posedge sys_clk);
        if (memCtrl.instructionCode !== 2'h0)
        begin
            chk(32'(memCtrl.instructionCode), 32'h0);
            results();
        end
        rd(8'h00, {24'h0, d & 8'he0});
    endtask : cmd
    initial
    begin
        int i;
        int k;
        logic [7:0] d;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        for (i = 0; i < 12; i++)
            rd(8'(i * 4), 32'h0);
        for (k = 0; k < 2; k++)
        begin
            for (i = 1; i < 8; i++)
            begin
                rnd = lfsr(rnd);
                d = rnd[7:0] & (i == 1 ? 8'h7f : 8'hff);
                wr(8'(i * 4), d);
                refReg[i] = i == 2 ? 8'h00 : d & msk[i];
            end
            for (i = 0; i < 8; i++)
                rd(8'(i * 4), {24'h0, refReg[i]});
            chk(32'(startX), xaddr(refReg[3], refReg[4]));
            chk(32'(stopX), xaddr(refReg[6], refReg[7]));
            chk(32'(yAddress), 32'(rev8(refReg[5])));
            chk(32'(voxCfg), 32'(refReg[1]));
        end
        voiceRaw <= 1'b1;
        silenceLevelRaw <= 2'h3;
        repeat (5) @(posedge sys_clk);
        rd(8'h08, 32'h0);
        wr(8'h24, 8'h05);
        wr(8'h00, 8'ha2);
        rd(8'h08, 32'h3);
        cmd(8'ha2);
        rd(8'h08, 32'h1);
        rd(8'h20, 32'h1);
        chk(32'(irq), 32'h1);
        wr(8'h28, 8'h01);
        rd(8'h20, 32'h0);
        chk(32'(irq), 32'h0);
        cmd(8'h01);
        rd(8'h08, 32'h0);
        chk(32'(irq), 32'h1);
        wr(8'h24, 8'h00);
        rd(8'h20, 32'h5);
        chk(32'(irq), 32'h0);
        wr(8'h28, 8'h0f);
        rnd = lfsr(rnd);
        wr(8'h04, 8'h80 | rnd[7:0]);
        for (k = 0; k < 4; k++)
        begin
            voiceRaw <= k[0];
            silenceLevelRaw <= k[1:0];
            repeat (5) @(posedge sys_clk);
            rd(8'h08, {24'h0, k[0], k[1:0], 5'h0});
        end
        rd(8'h20, 32'h2);
        wr(8'h08, 8'hff);
        rd(8'h08, 32'he0);
        wr(8'h2c, rnd[15:8]);
        rd(8'h2c, 32'h0);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h0c, 32'h0);
        chk(32'(yAddress), 32'h0);
        results();
    end
endmodule : vrv_regs_tb
